// ==== hw/lfm_regs.svh ====
// Purpose: register map, field positions and timing counts of the link fault monitor
// Assumes: 50 MHz system clock, AXI4-Lite byte addresses
// Notes: definitions only
`ifndef LFM_REGS_SVH
`define LFM_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LFM_ADDR_W 4
`define LFM_OFF_CTRL 4'h0
`define LFM_OFF_DRV 4'h4
`define LFM_OFF_STAT 4'h8

// ----------------------------------------
// field positions
// ----------------------------------------
`define LFM_CTRL_LOOP_LSB 0
`define LFM_CTRL_RXEN_LSB 4
`define LFM_CTRL_RATE_LSB 8
`define LFM_CTRL_LSEL_LSB 12
`define LFM_DRV_AMP_LSB 8
`define LFM_STAT_LF_LSB 0
`define LFM_STAT_FORCE_LSB 4
`define LFM_STAT_SETTLE_LSB 8
`define LFM_STAT_REF_LSB 12

// ----------------------------------------
// reset values
// ----------------------------------------
`define LFM_CTRL_RST 16'h0000
`define LFM_DRV_RST 10'h000

// ----------------------------------------
// timing
// ----------------------------------------
`define LFM_CLK_MHZ 50
`define LFM_TX_SETTLE_US 250
`define LFM_TX_SETTLE_CYC (`LFM_TX_SETTLE_US * `LFM_CLK_MHZ)
`define LFM_RX_INVALID_MS 2
`define LFM_RUN_LIMIT_BITS 60
`define LFM_RC_PERIOD_CHARS 4096
`define LFM_REF_LOSS_CYC 64
`define LFM_AMP_OFF 2'h0

`endif

// ==== hw/lfm_pkg.sv ====
// Purpose: types shared by the link fault monitor
// Assumes: nothing
// Notes: range control states are one-hot
`default_nettype none
package lfm_pkg;
    typedef enum logic [1:0] {
        LFM_RC_TRACK = 2'b01,
        LFM_RC_FORCE = 2'b10
    } lfm_rc_t;
    typedef logic [1:0] lfm_resp_t;
    localparam lfm_resp_t LFM_OKAY = 2'h0;
    localparam lfm_resp_t LFM_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== hw/lfm_link_fault_monitor.sv ====
// Purpose: quad channel serial-link control and link quality monitor
// Assumes: one 50 MHz clock; pin inputs are asynchronous and synchronised here
// Notes: recovered and reference clocks are sampled as levels, not used as clocks
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`default_nettype none
`include "lfm_regs.svh"

module lfm_link_fault_monitor
    import lfm_pkg::*;
#(
    parameter int unsigned TX_SETTLE_CYCLES = `LFM_TX_SETTLE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // axi4-lite write
    input wire logic [`LFM_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [`LFM_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // asynchronous pins
    input wire logic deviceResetN,
    input wire logic [3:0] serialInPrimary,
    input wire logic [3:0] serialInSecondary,
    input wire logic [3:0] recoveredClock,
    input wire logic [3:0] referenceClock,
    input wire logic [3:0] amplitudeGood,
    input wire logic [3:0] vcoOutOfRange,
    input wire logic [3:0] forcedFaultInput,
    // transmit shifter streams, same clock
    input wire logic [3:0] txSerial,
    // transmit side
    output logic [7:0] serialOut,
    output logic [7:0] serialOutEnable,
    output logic [3:0] txLogicPowerDown,
    // receive side
    output logic [3:0] rxChannelPowerDown,
    output logic [3:0] cdrData,
    output logic [3:0] cdrForceToRef,
    output logic [3:0] refMultiplyBy20,
    output logic [1:0] ampThresholdSel,
    output logic [3:0] ampDetectEnable,
    output logic [3:0] linkFaultN
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    localparam int SW = 29;
    logic [SW-1:0] syncA, syncB, next_syncA, next_syncB;
    logic devRstN;
    logic [3:0] inPri, inSec, recClk, refClk, ampOk, vcoOor, forcedFault;

    // first stage feeds only the second
    // no reset on the chain, it flushes while srst is held
    always_comb begin
        next_syncA = {deviceResetN, serialInPrimary, serialInSecondary, recoveredClock,
                      referenceClock, amplitudeGood, vcoOutOfRange, forcedFaultInput};
        next_syncB = syncA;
    end

    always_ff @(posedge clk) begin
        syncA <= next_syncA;
        syncB <= next_syncB;
    end

    assign {devRstN, inPri, inSec, recClk, refClk, ampOk, vcoOor, forcedFault} = syncB;

    // ----------------------------------------
    // register file and bus slave
    // ----------------------------------------
    // registers and bus state
    logic [15:0] ctrl, next_ctrl;
    logic [9:0] drv, next_drv;
    logic awHeld, wHeld, next_awHeld, next_wHeld;
    logic [`LFM_ADDR_W-1:0] wAddr, next_wAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic bValid, next_bValid, rValid, next_rValid;
    lfm_resp_t bResp, next_bResp, rResp, next_rResp;
    logic [31:0] rData, next_rData;

    // decoded fields and status
    logic [15:0] status;
    logic [3:0] loopback, rxEnable, lineSel, settling, refPresent, forcing;
    logic [7:0] drvEn;

    // control fields
    assign loopback = ctrl[`LFM_CTRL_LOOP_LSB +: 4];
    assign rxEnable = ctrl[`LFM_CTRL_RXEN_LSB +: 4];
    assign lineSel = ctrl[`LFM_CTRL_LSEL_LSB +: 4];
    assign drvEn = drv[7:0];
    assign status = {refPresent, settling, forcing, linkFaultN};

    // handshake outputs, readys are combinational
    assign s_axi_awready = !awHeld;
    assign s_axi_wready = !wHeld;
    assign s_axi_bvalid = bValid;
    assign s_axi_bresp = bResp;
    assign s_axi_arready = !rValid;
    assign s_axi_rvalid = rValid;
    assign s_axi_rresp = rResp;
    assign s_axi_rdata = rData;

    // address and data taken in either order, write done once both held
    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_wAddr = wAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bValid = bValid && !s_axi_bready;
        next_bResp = bResp;
        next_ctrl = ctrl;
        next_drv = drv;
        if (s_axi_awvalid && !awHeld) begin
            next_awHeld = 1'b1;
            next_wAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeld) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (awHeld && wHeld && !bValid) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bValid = 1'b1;
            next_bResp = LFM_OKAY;
            unique case ({wAddr[`LFM_ADDR_W-1:2], 2'h0})
                `LFM_OFF_CTRL: begin
                    if (wStrb[0]) next_ctrl[7:0] = wData[7:0];
                    if (wStrb[1]) next_ctrl[15:8] = wData[15:8];
                end
                `LFM_OFF_DRV: begin
                    if (wStrb[0]) next_drv[7:0] = wData[7:0];
                    if (wStrb[1]) next_drv[9:8] = wData[9:8];
                end
                `LFM_OFF_STAT: next_bResp = LFM_OKAY; // read only, write ignored
                default: next_bResp = LFM_SLVERR;
            endcase
        end
        // device reset pin wins over any write to the drive enables drv[7:0]
        if (!devRstN) next_drv[7:0] = 8'h00;
    end

    // read answer one cycle after address taken
    always_comb begin
        next_rValid = rValid && !s_axi_rready;
        next_rData = rData;
        next_rResp = rResp;
        if (s_axi_arvalid && !rValid) begin
            next_rValid = 1'b1;
            next_rResp = LFM_OKAY;
            unique case ({s_axi_araddr[`LFM_ADDR_W-1:2], 2'h0})
                `LFM_OFF_CTRL: next_rData = {16'h0000, ctrl};
                `LFM_OFF_DRV: next_rData = {22'h0, drv};
                `LFM_OFF_STAT: next_rData = {16'h0000, status};
                default: begin
                    next_rData = 32'h00000000;
                    next_rResp = LFM_SLVERR;
                end
            endcase
        end
    end

    // bus and register state
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= `LFM_CTRL_RST;
            drv <= `LFM_DRV_RST;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            wAddr <= '0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            bValid <= 1'b0;
            bResp <= LFM_OKAY;
            rValid <= 1'b0;
            rResp <= LFM_OKAY;
            rData <= 32'h00000000;
        end else begin
            ctrl <= next_ctrl;
            drv <= next_drv;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            wAddr <= next_wAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            bValid <= next_bValid;
            bResp <= next_bResp;
            rValid <= next_rValid;
            rResp <= next_rResp;
            rData <= next_rData;
        end
    end

    // ----------------------------------------
    // shared controls
    // ----------------------------------------
    // threshold select shared by all receivers
    assign ampThresholdSel = drv[`LFM_DRV_AMP_LSB +: 2];
    assign refMultiplyBy20 = ctrl[`LFM_CTRL_RATE_LSB +: 4];
    assign rxChannelPowerDown = ~rxEnable;

    // ----------------------------------------
    // per channel logic
    // ----------------------------------------
    for (genvar g = 0; g < 4; g++) begin : gCh
        // channel state and counters
        logic [1:0] sOut, next_sOut;
        logic [15:0] settleCnt, next_settleCnt;
        logic cdrBit, next_cdrBit;
        logic [5:0] runCnt, next_runCnt;
        logic [7:0] refCnt, next_refCnt;
        logic refPrev, recPrev, next_refPrev, next_recPrev;
        logic [11:0] tickCnt, next_tickCnt;
        lfm_rc_t rcState, next_rcState;
        logic lf, next_lf;
        logic txWasOff, next_txWasOff;
        logic recTick, noTrans, ampPass, lineGood, loopGood, linkGood;

        assign recTick = recClk[g] && !recPrev;
        assign noTrans = runCnt > 6'(`LFM_RUN_LIMIT_BITS);
        // amplitude ignored when detector off or looped back
        assign ampPass = loopback[g] || ampThresholdSel == `LFM_AMP_OFF || ampOk[g];
        // line checks need every condition; loopback keeps only range and transitions
        assign lineGood = ampPass && refPresent[g] && !forcedFault[g];
        assign loopGood = !noTrans && !vcoOor[g];
        assign linkGood = rxEnable[g] && loopGood && (loopback[g] || lineGood);

        // transmit drivers, loopback sends a steady one
        always_comb begin
            next_sOut = loopback[g] ? 2'h3 : {2{txSerial[g]}};
            next_txWasOff = drvEn[2*g +: 2] == 2'h0;
            next_settleCnt = settleCnt;
            if (txWasOff && drvEn[2*g +: 2] != 2'h0) begin
                next_settleCnt = 16'(TX_SETTLE_CYCLES);
            end else if (settleCnt != 16'h0000) begin
                next_settleCnt = settleCnt - 16'h0001;
            end
        end

        // recovery input select and transition run length
        always_comb begin
            next_cdrBit = loopback[g] ? txSerial[g]
                        : (lineSel[g] ? inSec[g] : inPri[g]);
            next_runCnt = runCnt;
            if (next_cdrBit != cdrBit) begin
                next_runCnt = 6'h00;
            end else if (runCnt <= 6'(`LFM_RUN_LIMIT_BITS)) begin
                next_runCnt = runCnt + 6'h01;
            end
        end

        // reference clock activity
        always_comb begin
            next_refPrev = refClk[g];
            next_refCnt = refCnt;
            if (refClk[g] != refPrev) begin
                next_refCnt = 8'h00;
            end else if (refCnt != 8'(`LFM_REF_LOSS_CYC)) begin
                next_refCnt = refCnt + 8'h01;
            end
        end

        // range control and link fault, stepped by recovered clock
        always_comb begin
            next_recPrev = recClk[g];
            next_tickCnt = tickCnt;
            next_rcState = rcState;
            next_lf = lf;
            if (!rxEnable[g]) begin
                next_tickCnt = 12'h000;
                next_rcState = LFM_RC_TRACK;
                next_lf = 1'b0;
            end else if (recTick) begin
                next_tickCnt = tickCnt + 12'h001;
                if (tickCnt == 12'(`LFM_RC_PERIOD_CHARS - 1)) begin
                    unique case (rcState)
                        LFM_RC_TRACK: if (vcoOor[g]) next_rcState = LFM_RC_FORCE;
                        LFM_RC_FORCE: next_rcState = LFM_RC_TRACK;
                    endcase
                end
                next_lf = linkGood && next_rcState == LFM_RC_TRACK;
            end
        end

        // channel registers
        always_ff @(posedge clk) begin
            if (srst) begin
                sOut <= 2'h0;
                settleCnt <= 16'h0000;
                txWasOff <= 1'b1;
                cdrBit <= 1'b0;
                runCnt <= 6'h00;
                refPrev <= 1'b0;
                refCnt <= 8'(`LFM_REF_LOSS_CYC);
                recPrev <= 1'b0;
                tickCnt <= 12'h000;
                rcState <= LFM_RC_TRACK;
                lf <= 1'b0;
            end else begin
                sOut <= next_sOut;
                settleCnt <= next_settleCnt;
                txWasOff <= next_txWasOff;
                cdrBit <= next_cdrBit;
                runCnt <= next_runCnt;
                refPrev <= next_refPrev;
                refCnt <= next_refCnt;
                recPrev <= next_recPrev;
                tickCnt <= next_tickCnt;
                rcState <= next_rcState;
                lf <= next_lf;
            end
        end

        // ----------------------------------------
        // per channel outputs
        // ----------------------------------------
        // transmit side
        assign serialOut[2*g +: 2] = sOut;
        assign serialOutEnable[2*g +: 2] = drvEn[2*g +: 2];
        assign txLogicPowerDown[g] = drvEn[2*g +: 2] == 2'h0;
        assign settling[g] = settleCnt != 16'h0000;

        // receive side and status
        assign refPresent[g] = refCnt != 8'(`LFM_REF_LOSS_CYC);
        assign forcing[g] = rcState == LFM_RC_FORCE;
        assign cdrForceToRef[g] = forcing[g];
        assign cdrData[g] = cdrBit;
        assign ampDetectEnable[g] = !loopback[g] && ampThresholdSel != `LFM_AMP_OFF;
        assign linkFaultN[g] = lf;
    end

endmodule
`default_nettype wire

// ==== tb/lfm_monitor.sv ====
// Purpose: port checks of the link fault monitor
// Assumes: one clock, srst high resets
// Notes: bound into every instance of the block
`default_nettype none
module lfm_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // watched ports
    input wire logic deviceResetN,
    input wire logic [3:0] recoveredClock,
    input wire logic [3:0] txSerial,
    input wire logic [7:0] serialOut,
    input wire logic [7:0] serialOutEnable,
    input wire logic [3:0] txLogicPowerDown,
    input wire logic [3:0] rxChannelPowerDown,
    input wire logic [3:0] cdrData,
    input wire logic [3:0] cdrForceToRef,
    input wire logic [1:0] ampThresholdSel,
    input wire logic [3:0] ampDetectEnable,
    input wire logic [3:0] linkFaultN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ----------------
    // assertions
    // ----------------
    // loopback shows as threshold set with detector off
    loop_out_a: assert property (
        ampThresholdSel != 2'h0 && !ampDetectEnable[0] |=> serialOut[1:0] == 2'h3)
        else $error("loopback pair not high");
    loop_cdr_a: assert property (
        ampThresholdSel != 2'h0 && !ampDetectEnable[0] |=> cdrData[0] == $past(txSerial[0]))
        else $error("loopback stream not recovered");
    tx_power_a: assert property (
        txLogicPowerDown[1:0] == {~|serialOutEnable[3:2], ~|serialOutEnable[1:0]})
        else $error("transmit power down wrong");
    rx_off_a: assert property (
        rxChannelPowerDown != 4'h0 |=> (linkFaultN & $past(rxChannelPowerDown)) == 4'h0)
        else $error("disabled channel without fault");
    force_low_a: assert property ((cdrForceToRef & linkFaultN) == 4'h0)
        else $error("good link while forced");
    amp_off_a: assert property (
        ampThresholdSel == 2'h0 |-> ampDetectEnable == 4'h0)
        else $error("detector on at threshold off");
    tick_hold_a: assert property (
        (!rxChannelPowerDown[3] && $stable(recoveredClock[3])) [*6] |=> $stable(linkFaultN[3]))
        else $error("fault moved without clock");
    pin_reset_a: assert property (!deviceResetN [*4] |-> serialOutEnable == 8'h00)
        else $error("drivers on in device reset");
    good_cause_a: assert property (
        $rose(linkFaultN[0]) |-> !rxChannelPowerDown[0] && !cdrForceToRef[0])
        else $error("good link without cause");
    // main scenarios
    cover property ($rose(cdrForceToRef[0]));
    cover property ($rose(linkFaultN[0]));
    cover property ($fell(serialOutEnable[0]));
endmodule
bind lfm_link_fault_monitor lfm_monitor mon (.clk(clk), .srst(srst),
    .deviceResetN(deviceResetN), .recoveredClock(recoveredClock), .txSerial(txSerial),
    .serialOut(serialOut), .serialOutEnable(serialOutEnable),
    .txLogicPowerDown(txLogicPowerDown), .rxChannelPowerDown(rxChannelPowerDown),
    .cdrData(cdrData), .cdrForceToRef(cdrForceToRef), .ampThresholdSel(ampThresholdSel),
    .ampDetectEnable(ampDetectEnable), .linkFaultN(linkFaultN));
`default_nettype wire

// ==== tb/lfm_far_end.sv ====
// Purpose: far end model, remote transmitter and clock sources
// Assumes: driven from the bench clock
// Notes: character clock lasts four bench cycles
`default_nettype none
module lfm_far_end (
    // clock
    input wire logic clk,
    // scenario controls
    input wire logic [3:0] quiet,
    input wire logic [3:0] clkStop,
    input wire logic refStop,
    // line side
    output logic [3:0] serialInPrimary,
    output logic [3:0] serialInSecondary,
    output logic [3:0] recoveredClock,
    output logic [3:0] referenceClock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase = 2'h0;
    logic [3:0] line = 4'h0;
    // ----------------
    // line and clocks
    // ----------------
    // a quiet channel holds its primary line flat
    always @(posedge clk) begin
        phase <= phase + 2'h1;
        line <= line ^ ~quiet;
    end
    // outputs
    assign serialInPrimary = line;
    assign serialInSecondary = {4{phase[0]}};
    assign recoveredClock = {4{phase[1]}} & ~clkStop;
    assign referenceClock = refStop ? 4'h0 : {4{phase[0]}};
endmodule
`default_nettype wire

// ==== tb/lfm_link_fault_monitor_bench.sv ====
// Purpose: self-checking bench of the link fault monitor
// Assumes: 50 MHz clock, far end model on the line side
// Notes: settle count cut to 20 cycles
`default_nettype none
`include "lfm_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module lfm_link_fault_monitor_bench
    import lfm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, srst = 1'b1, devRstN = 1'b1, refStop = 1'b0;
    logic awV = 1'b0, wV = 1'b0, bRdy = 1'b0, arV = 1'b0, rRdy = 1'b0;
    logic [3:0] awA = 4'h0, arA = 4'h0, ampGood = 4'hf, vcoOor = 4'h0, forceF = 4'h0;
    logic [3:0] txSer = 4'h0, quiet = 4'h0, clkStop = 4'h0;
    logic [31:0] wD = 32'h0, rD;
    lfm_resp_t bResp, rResp;
    logic awRdy, wRdy, bV, arRdy, rV;
    logic [3:0] pri, sec, rcClk, refClk, txPd, rxPd, forceRef, x20, ampEn, linkFaultN;
    logic [7:0] serialOut, serialOutEnable;
    logic [1:0] ampSel;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    // ----------------
    // structure
    // ----------------
    lfm_link_fault_monitor #(.TX_SETTLE_CYCLES(20)) uut (.clk(clk), .srst(srst),
        .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bResp),
        .s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV),
        .s_axi_arready(arRdy), .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV),
        .s_axi_rready(rRdy), .deviceResetN(devRstN), .serialInPrimary(pri),
        .serialInSecondary(sec), .recoveredClock(rcClk), .referenceClock(refClk),
        .amplitudeGood(ampGood), .vcoOutOfRange(vcoOor), .forcedFaultInput(forceF),
        .txSerial(txSer), .serialOut(serialOut), .serialOutEnable(serialOutEnable),
        .txLogicPowerDown(txPd), .rxChannelPowerDown(rxPd), .cdrData(),
        .cdrForceToRef(forceRef), .refMultiplyBy20(x20), .ampThresholdSel(ampSel),
        .ampDetectEnable(ampEn), .linkFaultN(linkFaultN));
    lfm_far_end far (.clk(clk), .quiet(quiet), .clkStop(clkStop), .refStop(refStop),
        .serialInPrimary(pri), .serialInSecondary(sec), .recoveredClock(rcClk),
        .referenceClock(refClk));
    // clock
    always #10 clk = ~clk;
    // ----------------
    // bus tasks
    // ----------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one write, address and data offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input lfm_resp_t er);
        awA <= a;
        wD <= d;
        awV <= 1'b1;
        wV <= 1'b1;
        bRdy <= 1'b1;
        do begin
            @(posedge clk);
            if (awRdy) awV <= 1'b0;
            if (wRdy) wV <= 1'b0;
        end while (bV !== 1'b1);
        `CHK("write resp", er, bResp)
        bRdy <= 1'b0;
        @(posedge clk);
    endtask
    // one read, data compared under mask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
            input lfm_resp_t er);
        arA <= a;
        arV <= 1'b1;
        rRdy <= 1'b1;
        do begin
            @(posedge clk);
            if (arRdy) arV <= 1'b0;
        end while (rV !== 1'b1);
        `CHK("read data", e, rD & m)
        `CHK("read resp", er, rResp)
        rRdy <= 1'b0;
        @(posedge clk);
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_regs();
        `CHK("drv on", 8'h00, serialOutEnable)
        `CHK("tx down", 4'hf, txPd)
        `CHK("fault", 4'h0, linkFaultN)
        rd(`LFM_OFF_CTRL, 32'hffff, 32'h0, LFM_OKAY);
        rd(`LFM_OFF_DRV, 32'h3ff, 32'h0, LFM_OKAY);
        wr(`LFM_OFF_STAT, 32'hffff, LFM_OKAY);
        rd(`LFM_OFF_STAT, 32'hff, 32'h0, LFM_OKAY);
        wr(4'hc, 32'h1, LFM_SLVERR);
        rd(4'hc, 32'hffffffff, 32'h0, LFM_SLVERR);
        wr(`LFM_OFF_CTRL, 32'ha00, LFM_OKAY);
        `CHK("rate", 4'ha, x20)
        `CHK("rx down", 4'hf, rxPd)
    endtask
    task automatic t_drv();
        wr(`LFM_OFF_DRV, 32'h31, LFM_OKAY);
        rd(`LFM_OFF_STAT, 32'hf00, 32'h500, LFM_OKAY);
        `CHK("drv on", 8'h31, serialOutEnable)
        `CHK("tx down", 4'ha, txPd)
        txSer <= 4'h5;
        repeat (30) @(posedge clk);
        `CHK("tx data", 8'h33, serialOut)
        rd(`LFM_OFF_STAT, 32'hf00, 32'h0, LFM_OKAY);
        for (int t = 0; t < 4; t++) begin
            wr(`LFM_OFF_DRV, {22'h0, t[1:0], 8'h31}, LFM_OKAY);
            `CHK("threshold", t[1:0], ampSel)
            `CHK("amp on", (t == 0) ? 4'h0 : 4'hf, ampEn)
        end
        wr(`LFM_OFF_CTRL, 32'h2, LFM_OKAY);
        @(posedge clk);
        `CHK("loop out", 8'h3f, serialOut)
        `CHK("loop amp", 4'hd, ampEn)
    endtask
    task automatic t_pin();
        devRstN <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("pin off", 8'h00, serialOutEnable)
        wr(`LFM_OFF_DRV, 32'h31, LFM_OKAY);
        `CHK("pin blocks", 8'h00, serialOutEnable)
        devRstN <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("pin after", 8'h00, serialOutEnable)
    endtask
    task automatic t_link();
        wr(`LFM_OFF_DRV, 32'h100, LFM_OKAY);
        wr(`LFM_OFF_CTRL, 32'hf0, LFM_OKAY);
        repeat (200) @(posedge clk);
        `CHK("good", 4'hf, linkFaultN)
        forceF <= 4'h2;
        ampGood <= 4'hb;
        repeat (20) @(posedge clk);
        `CHK("forced amp", 4'h9, linkFaultN)
        forceF <= 4'h0;
        ampGood <= 4'hf;
        quiet <= 4'h8;
        repeat (100) @(posedge clk);
        `CHK("flat", 4'h7, linkFaultN)
        wr(`LFM_OFF_CTRL, 32'h80f0, LFM_OKAY);
        repeat (100) @(posedge clk);
        `CHK("alt line", 4'hf, linkFaultN)
        clkStop <= 4'h8;
        repeat (8) @(posedge clk);
        ampGood <= 4'h7;
        repeat (30) @(posedge clk);
        `CHK("no tick", 1'b1, linkFaultN[3])
        clkStop <= 4'h0;
        repeat (20) @(posedge clk);
        `CHK("tick", 1'b0, linkFaultN[3])
        ampGood <= 4'hf;
        refStop <= 1'b1;
        repeat (120) @(posedge clk);
        `CHK("no ref", 4'h0, linkFaultN)
        refStop <= 1'b0;
        wr(`LFM_OFF_CTRL, 32'h80f1, LFM_OKAY);
        ampGood <= 4'he;
        forceF <= 4'h1;
        repeat (100) begin
            @(posedge clk);
            txSer <= ~txSer;
        end
        `CHK("loop good", 1'b1, linkFaultN[0])
        repeat (100) @(posedge clk);
        `CHK("loop flat", 1'b0, linkFaultN[0])
        ampGood <= 4'hf;
        forceF <= 4'h0;
        wr(`LFM_OFF_CTRL, 32'h80d1, LFM_OKAY);
        @(posedge clk);
        `CHK("rx off", 1'b0, linkFaultN[1])
    endtask
    task automatic t_range();
        int n;
        wr(`LFM_OFF_CTRL, 32'hf0, LFM_OKAY);
        vcoOor <= 4'h1;
        for (n = 0; n < 20000 && forceRef[0] !== 1'b1; n++) @(posedge clk);
        `CHK("forced", 1'b0, linkFaultN[0])
        vcoOor <= 4'h0;
        for (n = 0; n < 20000 && forceRef[0] !== 1'b0; n++) @(posedge clk);
        `CHK("period", 1'b1, n > 16380 && n < 16390)
        repeat (20) @(posedge clk);
        `CHK("relock", 1'b1, linkFaultN[0])
    endtask
    // cut a hung run short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            complete_run();
        end
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_drv();
        t_pin();
        t_link();
        t_range();
        complete_run();
    end
endmodule
`default_nettype wire
